// File: mis_pkg.sv
// Package for the microphone ADC interrupt status block.
// Assumes a register port with byte address and one-cycle strobes.
package mis_pkg;
  localparam logic [7:0] MIS_MASK_ADDR = 8'h35;
  localparam logic [7:0] MIS_STAT_ADDR = 8'h36;
  localparam logic [7:0] MIS_MASK_RESET = 8'hff;
  localparam int MIS_BIT_PDN = 7;
  localparam int MIS_BIT_THERM = 6;
  localparam int MIS_BIT_SYNC = 5;
  localparam int MIS_BIT_CLIP_LO = 1;
  localparam int MIS_BIT_MUTE = 0;
  localparam int MIS_NUM_SRC = 8;
endpackage

// File: mis_sync_if.sv
// Interface carrying raw and synchronised event levels.
// Assumes one clock shared by producer and consumer.
`timescale 1ns/1ps
interface mis_sync_if;
  logic [7:0] raw;
  logic [7:0] level;
  modport src (output raw, input level);
  modport snk (input raw, output level);
endinterface

// File: mis_sync.sv
// Three-stage synchroniser for the eight event sources.
// Assumes sources come from outside the clock domain.
`timescale 1ns/1ps
module mis_sync
  import mis_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  mis_sync_if.snk sif // Raw in, settled out
);
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;
  logic [7:0] lvl_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
    end else begin
      s1_ff <= sif.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Change counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      lvl_ff <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign sif.level = lvl_ff;
endmodule

// File: mis_top.sv
// Sticky interrupt status and mask registers of a quad microphone ADC.
// Assumes a decoded register port: addr, wr_en, rd_en one-cycle strobes.
`timescale 1ns/1ps
module mis_top
  import mis_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic reg_wr_en, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd_en, // Read strobe
  output logic [7:0] reg_rdata_ff, // Read data, held
  output logic reg_rvalid_ff, // Read data valid pulse
  input wire logic powerdown_complete, // Device fully powered down
  input wire logic thermal_sense_en, // Thermal sensing enabled
  input wire logic thermal_over_limit, // Junction over limit
  input wire logic sync_confirmed, // Multichip sync confirmed
  input wire logic [3:0] channel_clip, // Clip per path {2b,2a,1b,1a}
  input wire logic mute_pin, // Mute input asserted
  output logic irq_ff // Interrupt request, active high
);
  logic [7:0] clip_event_mask_ff;
  logic [7:0] event_status_ff;
  logic [7:0] nxt_status;
  logic [7:0] prev_lvl_ff;
  logic [7:0] cond;
  logic stat_rd;
  mis_sync_if sif ();

  // ----------------------------------------
  // Source gathering
  // ----------------------------------------
  // bit mapping
  always_comb begin
    sif.raw = 8'h00;
    sif.raw[MIS_BIT_PDN] = powerdown_complete;
    sif.raw[MIS_BIT_THERM] = thermal_sense_en & thermal_over_limit;
    sif.raw[MIS_BIT_SYNC] = sync_confirmed;
    sif.raw[MIS_BIT_CLIP_LO +: 4] = channel_clip;
    sif.raw[MIS_BIT_MUTE] = mute_pin;
  end

  mis_sync u_sync (
    .clock(clock),
    .rst(rst),
    .sif(sif)
  );

  // Previous levels, kept for the clip rise check
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_lvl_ff <= 8'h00;
    end else begin
      prev_lvl_ff <= sif.level;
    end
  end

  // Every bit, clip included, re-arms from its level after a read
  always_comb begin
    cond = sif.level;
  end

  // ----------------------------------------
  // Mask register
  // ----------------------------------------
  // mask write, resets masked
  always_ff @(posedge clock) begin
    if (rst) begin
      clip_event_mask_ff <= MIS_MASK_RESET;
    end else if (reg_wr_en && reg_addr == MIS_MASK_ADDR) begin
      clip_event_mask_ff <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Sticky status
  // ----------------------------------------
  assign stat_rd = reg_rd_en && (reg_addr == MIS_STAT_ADDR);

  always_comb begin
    nxt_status = event_status_ff | cond;
    if (stat_rd) begin
      nxt_status = cond;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_status_ff <= 8'h00;
    end else begin
      event_status_ff <= nxt_status;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // host reads singly; no auto-increment here
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd_en;
      if (reg_rd_en) begin
        if (reg_addr == MIS_MASK_ADDR) begin
          reg_rdata_ff <= clip_event_mask_ff;
        end else if (reg_addr == MIS_STAT_ADDR) begin
          reg_rdata_ff <= event_status_ff;
        end else begin
          reg_rdata_ff <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // unmasked status drives request
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & ~clip_event_mask_ff);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_status_sticky: assert property (
    @(posedge clock) disable iff (rst)
    (!stat_rd && event_status_ff[MIS_BIT_MUTE]) |=>
      event_status_ff[MIS_BIT_MUTE])
    else $error("Status bit dropped without read");

  a_mute_sets: assert property (
    @(posedge clock) disable iff (rst)
    $rose(sif.level[MIS_BIT_MUTE]) |=> event_status_ff[MIS_BIT_MUTE])
    else $error("Mute event not latched");

  a_pdn_sets: assert property (
    @(posedge clock) disable iff (rst)
    sif.level[MIS_BIT_PDN] |=> event_status_ff[MIS_BIT_PDN])
    else $error("Power down done not latched");

  a_therm_gate: assert property (
    @(posedge clock) disable iff (rst)
    (thermal_sense_en && thermal_over_limit)[*5] |=>
      event_status_ff[MIS_BIT_THERM])
    else $error("Thermal trip not latched");

  a_sync_sets: assert property (
    @(posedge clock) disable iff (rst)
    sync_confirmed[*5] |=> event_status_ff[MIS_BIT_SYNC])
    else $error("Sync done not latched");

  a_clip_sets: assert property (
    @(posedge clock) disable iff (rst)
    channel_clip[3][*5] |=> event_status_ff[MIS_BIT_CLIP_LO + 3])
    else $error("Clip bit not latched");

  a_irq_masked: assert property (
    @(posedge clock) disable iff (rst)
    ((event_status_ff & ~clip_event_mask_ff) == 8'h00 &&
     (cond & ~clip_event_mask_ff) == 8'h00) |=> !irq_ff)
    else $error("Interrupt raised while all masked");

  a_mask_reset: assert property (
    @(posedge clock)
    rst |=> clip_event_mask_ff == MIS_MASK_RESET)
    else $error("Mask not masked after reset");

  a_read_clears: assert property (
    @(posedge clock) disable iff (rst)
    (stat_rd && cond == 8'h00) |=> event_status_ff == 8'h00)
    else $error("Status read did not clear");

  a_irq_follows: assert property (
    @(posedge clock) disable iff (rst)
    irq_ff == |(event_status_ff & ~$past(clip_event_mask_ff)))
    else $error("Interrupt disagrees with status");

  a_clip_rise_irq: assert property (
    @(posedge clock) disable iff (rst)
    ((sif.level[MIS_BIT_CLIP_LO +: 4] &
      ~prev_lvl_ff[MIS_BIT_CLIP_LO +: 4] &
      ~clip_event_mask_ff[MIS_BIT_CLIP_LO +: 4]) != 4'h0) |=> irq_ff)
    else $error("Unmasked clip rise gave no interrupt");

  a_therm_disabled: assert property (
    @(posedge clock) disable iff (rst)
    (!thermal_sense_en)[*6] ##0 !event_status_ff[MIS_BIT_THERM] |=>
      !event_status_ff[MIS_BIT_THERM])
    else $error("Thermal bit set while sensing off");

  a_read_data: assert property (
    @(posedge clock) disable iff (rst)
    stat_rd |=> reg_rvalid_ff && reg_rdata_ff == $past(event_status_ff))
    else $error("Status read returned wrong value");

  a_status_no_write: assert property (
    @(posedge clock) disable iff (rst)
    (reg_wr_en && reg_addr == MIS_STAT_ADDR && !stat_rd && cond == 8'h00)
      |=> event_status_ff == $past(event_status_ff))
    else $error("Status changed by a write");

  a_mask_write: assert property (
    @(posedge clock) disable iff (rst)
    (reg_wr_en && reg_addr == MIS_MASK_ADDR) |=>
      clip_event_mask_ff == $past(reg_wdata))
    else $error("Mask write did not land");

  a_rvalid_req: assert property (
    @(posedge clock) disable iff (rst)
    !reg_rd_en |=> !reg_rvalid_ff)
    else $error("Read answer without a request");
endmodule

// File: mis_host_model.sv
// Host model driving the decoded register port of the status block.
// Assumes strobes are sampled on the rising clock, rvalid one cycle later.
`timescale 1ns/1ps
module mis_host_model (
  input wire logic clock, // System clock
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr_en, // Write strobe
  output logic [7:0] reg_wdata, // Write data
  output logic reg_rd_en, // Read strobe
  input wire logic [7:0] reg_rdata_ff, // Read data
  input wire logic reg_rvalid_ff, // Read data valid
  output logic to_flag // Answer never came
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    to_flag = 1'b0;
  end

  // Idle bus shows inverted values so stale data cannot match
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
    reg_addr <= ~a;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clock);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    n = 0;
    while (reg_rvalid_ff !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (reg_rvalid_ff !== 1'b1) to_flag = 1'b1;
    d = reg_rdata_ff;
  endtask
endmodule

// File: mic_adc_interrupt_status_tb_top.sv
// Self-checking bench for the sticky interrupt status block.
// Assumes the host model drives the register port; sources are levels.
`timescale 1ns/1ps
module mic_adc_interrupt_status_tb_top;
  import mis_pkg::*;
  logic clock;
  logic rst;
  logic [7:0] src;
  logic sense_en;
  logic [7:0] addr;
  logic wr_en;
  logic [7:0] wdata;
  logic rd_en;
  logic [7:0] rdata;
  logic rvalid;
  logic irq;
  logic to_flag;
  int err_total;
  int checks_done;

  mis_top dut_u (.clock(clock), .rst(rst), .reg_addr(addr),
    .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en),
    .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid),
    .powerdown_complete(src[7]), .thermal_sense_en(sense_en),
    .thermal_over_limit(src[6]), .sync_confirmed(src[5]),
    .channel_clip(src[4:1]), .mute_pin(src[0]), .irq_ff(irq));
  mis_host_model host_u (.clock(clock), .reg_addr(addr),
    .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en),
    .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .to_flag(to_flag));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------
  // Shared checks
  // ----------------------------------------
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    if (to_flag === 1'b1) begin
      err_total++;
      $display("[ERR] t=%0t rvalid=%h exp=%h", $time, rvalid, 1'b1);
      end_sim();
    end
    chk(d, e);
  endtask
  // Irq looked at just after an edge, once settled
  task chk_irq(input logic e);
    @(posedge clock);
    #1;
    chk({7'h00, irq}, {7'h00, e});
  endtask
  // Sources change on a rising edge only
  task drive_src(input logic [7:0] v);
    @(posedge clock);
    src <= v;
  endtask
  task end_sim;
    $display("err_total=%0d checks_done=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rdc(MIS_MASK_ADDR, MIS_MASK_RESET);
    rdc(MIS_STAT_ADDR, 8'h00);
    chk_irq(1'b0);
  endtask
  // Pulse each source once; bit stays after the source goes away
  task t_sources;
    for (int i = 0; i < MIS_NUM_SRC; i++) begin
      drive_src(8'h01 << i);
      repeat (8) @(posedge clock);
      drive_src(8'h00);
      repeat (8) @(posedge clock);
      rdc(MIS_STAT_ADDR, 8'h01 << i);
      rdc(MIS_STAT_ADDR, 8'h00);
      chk_irq(1'b0);
    end
  endtask
  task t_therm_off;
    @(posedge clock);
    sense_en <= 1'b0;
    src <= 8'h40;
    repeat (8) @(posedge clock);
    rdc(MIS_STAT_ADDR, 8'h00);
    src <= 8'h00;
    repeat (8) @(posedge clock);
    sense_en <= 1'b1;
  endtask
  task t_persist;
    drive_src(8'h02);
    repeat (8) @(posedge clock);
    rdc(MIS_STAT_ADDR, 8'h02);
    rdc(MIS_STAT_ADDR, 8'h02);
    drive_src(8'h00);
    repeat (8) @(posedge clock);
    rdc(MIS_STAT_ADDR, 8'h02);
    rdc(MIS_STAT_ADDR, 8'h00);
  endtask
  // Clip with mask closed, then open it, then clear by read
  task t_mask;
    host_u.wr(MIS_STAT_ADDR, 8'hff);
    rdc(MIS_STAT_ADDR, 8'h00);
    drive_src(8'h04);
    repeat (8) @(posedge clock);
    chk_irq(1'b0);
    host_u.wr(MIS_MASK_ADDR, 8'hfb);
    repeat (3) @(posedge clock);
    chk_irq(1'b1);
    rdc(MIS_MASK_ADDR, 8'hfb);
    drive_src(8'h00);
    repeat (8) @(posedge clock);
    rdc(MIS_STAT_ADDR, 8'h04);
    repeat (3) @(posedge clock);
    chk_irq(1'b0);
    rdc(8'h40, 8'h00);
    host_u.wr(MIS_MASK_ADDR, 8'hff);
  endtask
  // One mask bit open at a time; a masked neighbour stays quiet
  task t_mask_each;
    logic [7:0] nb;
    for (int i = 0; i < MIS_NUM_SRC; i++) begin
      nb = 8'h01 << ((i + 1) % MIS_NUM_SRC);
      host_u.wr(MIS_MASK_ADDR, ~(8'h01 << i));
      drive_src(nb);
      repeat (8) @(posedge clock);
      chk_irq(1'b0);
      drive_src(8'h01 << i);
      repeat (8) @(posedge clock);
      chk_irq(1'b1);
      drive_src(8'h00);
      repeat (8) @(posedge clock);
      rdc(MIS_STAT_ADDR, (8'h01 << i) | nb);
      chk_irq(1'b0);
    end
    host_u.wr(MIS_MASK_ADDR, MIS_MASK_RESET);
  endtask
  // Mid-run reset brings back masked, cleared state
  task t_rereset;
    host_u.wr(MIS_MASK_ADDR, 8'h00);
    drive_src(8'h01);
    repeat (8) @(posedge clock);
    chk_irq(1'b1);
    @(posedge clock);
    rst <= 1'b1;
    src <= 8'h00;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rdc(MIS_MASK_ADDR, MIS_MASK_RESET);
    rdc(MIS_STAT_ADDR, 8'h00);
    chk_irq(1'b0);
  endtask

  initial begin
    rst = 1'b1;
    src = 8'h00;
    sense_en = 1'b1;
    err_total = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_sources();
    t_therm_off();
    t_persist();
    t_mask();
    t_mask_each();
    t_rereset();
    end_sim();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("[ERR] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  end
endmodule
